// ---- smc_defs.vh ----
// Constants shared by the sleep mode controller files.
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// ****************************************************************
// Sleep mode codes
// ****************************************************************
`define SMC_MODE_IDLE      3'h0
`define SMC_MODE_NOISE     3'h1
`define SMC_MODE_PDOWN     3'h2
`define SMC_MODE_PSAVE     3'h3
`define SMC_MODE_RSV4      3'h4
`define SMC_MODE_RSV5      3'h5
`define SMC_MODE_STANDBY   3'h6
`define SMC_MODE_XSTANDBY  3'h7
// ****************************************************************
// Timing
// ****************************************************************
`define SMC_CLK_MHZ        200
`define SMC_IRQ_HOLD       16'h0004
`define SMC_STANDBY_WAKE   16'h0006
`define SMC_BOD_WAKE_NS    60000
`define SMC_CNT_W          16
`define SMC_CNT_ONE        16'h0001
`define SMC_CNT_ZERO       16'h0000
`define SMC_TSEQ_WIN       3'h4
`define SMC_TSEQ_ZERO      3'h0
`define SMC_TSEQ_ONE       3'h1
`define SMC_FUSE_W         4
`define SMC_FUSE_SHIFT     8
`define SMC_FUSE_BASE      16'h0010
`endif

// ---- smc_wake_counter.v ----
// Wake-up delay counter loaded with a start-up length and counting down to done.
`timescale 1ns/100ps
`include "smc_defs.vh"
module smc_wake_counter (
    input  wire                   clk,
    input  wire                   rstn,
    input  wire                   load,
    input  wire [`SMC_CNT_W-1:0]  length,
    output reg                    busy,
    output reg                    done
);
    reg [`SMC_CNT_W-1:0] count;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= `SMC_CNT_ZERO;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                count <= length;
                busy  <= 1'b1;
            end else if (busy) begin
                if (count <= `SMC_CNT_ONE) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - `SMC_CNT_ONE;
                end
            end
        end
    end
endmodule

// ---- smc_sleep_ctrl.v ----
// Sleep mode controller: mode entry, clock gating, wake sources and start-up delay.
`timescale 1ns/100ps
`include "smc_defs.vh"
module smc_sleep_ctrl (
    input  wire                   clk,
    input  wire                   rstn,
    input  wire                   sleep_instr,
    input  wire                   sleep_arm,
    input  wire [2:0]             sleep_select,
    input  wire [`SMC_FUSE_W-1:0] clock_select_fuse,
    input  wire                   brownout_sleep_disable_enable_wr,
    input  wire                   brownout_sleep_disable_wr,
    input  wire                   brownout_sleep_disable_wdata,
    input  wire                   global_irq_en,
    input  wire [1:0]             timer2_irq_mask,
    input  wire                   timer2_enabled,
    input  wire                   timer2_async,
    input  wire                   adc_enabled,
    input  wire                   ext_reset_pin,
    input  wire                   wdt_reset,
    input  wire                   wdt_irq,
    input  wire                   bod_reset,
    input  wire                   twi_match,
    input  wire                   timer_irq,
    input  wire [1:0]             timer2_event,
    input  wire                   store_ready_irq,
    input  wire                   adc_done_irq,
    input  wire [2:0]             ext_irq_pin,
    input  wire [2:0]             ext_irq_level_mode,
    input  wire                   pin_change_irq,
    input  wire                   other_io_irq,
    output reg                    core_clock_domain,
    output reg                    program_store_clock,
    output reg                    peripheral_clock_domain,
    output reg                    converter_clock_domain,
    output reg                    async_timer_clock,
    output reg                    main_osc_en,
    output reg                    timer_osc_en,
    output reg                    brownout_detector_en,
    output reg                    brownout_sleep_disable,
    output reg                    adc_start,
    output reg                    irq_take,
    output reg                    reset_vector_go,
    output reg                    asleep
);
    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam [`SMC_CNT_W-1:0] BOD_WAKE_CYC =
        (`SMC_BOD_WAKE_NS * `SMC_CLK_MHZ) / 1000;
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_SLEEP = 2'h1;
    localparam [1:0] ST_START = 2'h2;
    localparam [1:0] ST_HOLD  = 2'h3;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Pins pass three flops; a change counts once stages two and three agree.
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    reg [3:0] sync_c;
    reg [3:0] pin_state;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_a    <= 4'h0;
            sync_b    <= 4'h0;
            sync_c    <= 4'h0;
            pin_state <= 4'h0;
        end else begin
            sync_a <= {ext_reset_pin, ext_irq_pin};
            sync_b <= sync_a;
            sync_c <= sync_b;
            pin_state <= (sync_b & sync_c) | (pin_state & (sync_b | sync_c));
        end
    end
    wire       ext_rst_s = pin_state[3];
    wire [2:0] ext_pin_s = pin_state[2:0];

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    function is_deep;
        input [2:0] m;
        begin
            is_deep = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE) ||
                      (m == `SMC_MODE_STANDBY) || (m == `SMC_MODE_XSTANDBY);
        end
    endfunction
    function is_save;
        input [2:0] m;
        begin
            is_save = (m == `SMC_MODE_PSAVE) || (m == `SMC_MODE_XSTANDBY);
        end
    endfunction

    reg  [1:0] state;
    reg  [2:0] mode;
    reg        bod_was_off;
    reg        wake_by_irq;
    reg        wake_by_rst;
    reg  [2:0] tseq;

    wire any_reset = ext_rst_s | wdt_reset | bod_reset;
    // Edge-configured pins are masked out of waking except in idle.
    wire [2:0] ext_wake_pins = ext_pin_s &
        ((mode == `SMC_MODE_IDLE) ? 3'h7 : ext_irq_level_mode);
    wire ext_wake = |ext_wake_pins;
    wire t2_wake = global_irq_en & |(timer2_event & timer2_irq_mask);

    reg wake_irq;
    always @* begin
        wake_irq = 1'b0;
        case (mode)
            `SMC_MODE_IDLE:
                wake_irq = wdt_irq | twi_match | timer_irq | t2_wake | store_ready_irq |
                           adc_done_irq | ext_wake | pin_change_irq | other_io_irq;
            `SMC_MODE_NOISE:
                wake_irq = adc_done_irq | wdt_irq | twi_match | (timer_irq & timer2_async) |
                           store_ready_irq | ext_wake | pin_change_irq;
            `SMC_MODE_PSAVE, `SMC_MODE_XSTANDBY:
                wake_irq = wdt_irq | twi_match | ext_wake | pin_change_irq |
                           (t2_wake & timer2_enabled);
            default:
                wake_irq = wdt_irq | twi_match | ext_wake | pin_change_irq;
        endcase
    end

    // ****************************************************************
    // Start-up length
    // ****************************************************************
    reg [`SMC_CNT_W-1:0] start_len;
    always @* begin
        start_len = `SMC_CNT_ONE;
        if (mode == `SMC_MODE_STANDBY || mode == `SMC_MODE_XSTANDBY)
            start_len = `SMC_STANDBY_WAKE;
        else if (is_deep(mode))
            start_len = `SMC_FUSE_BASE +
                        ({{(`SMC_CNT_W-`SMC_FUSE_W){1'b0}}, clock_select_fuse} << `SMC_FUSE_SHIFT);
        if (bod_was_off && start_len < BOD_WAKE_CYC)
            start_len = BOD_WAKE_CYC;
    end

    // ****************************************************************
    // Wake counter
    // ****************************************************************
    // The hold count is loaded at the very edge that ends the start-up, under the same
    // condition that moves the sequencer into the hold, so the hold always gets its done.
    wire cnt_done;
    wire cnt_load  = (state == ST_SLEEP) && (wake_irq || any_reset);
    wire hold_load = (state == ST_START) && cnt_done && !wake_by_rst && !any_reset && wake_irq;
    smc_wake_counter u_cnt (
        .clk    (clk),
        .rstn   (rstn),
        .load   (cnt_load | hold_load),
        .length (hold_load ? `SMC_IRQ_HOLD : start_len),
        .busy   (),
        .done   (cnt_done)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Reserved codes are treated as idle so a stray write cannot strand the core.
    wire [2:0] sel_mode = (sleep_select == `SMC_MODE_RSV4 || sleep_select == `SMC_MODE_RSV5) ?
                          `SMC_MODE_IDLE : sleep_select;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state           <= ST_RUN;
            mode            <= `SMC_MODE_IDLE;
            bod_was_off     <= 1'b0;
            wake_by_irq     <= 1'b0;
            wake_by_rst     <= 1'b0;
            adc_start       <= 1'b0;
            irq_take        <= 1'b0;
            reset_vector_go <= 1'b0;
        end else begin
            adc_start       <= 1'b0;
            irq_take        <= 1'b0;
            reset_vector_go <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (sleep_instr && sleep_arm) begin
                        state       <= ST_SLEEP;
                        mode        <= sel_mode;
                        bod_was_off <= brownout_sleep_disable & is_deep(sel_mode);
                        wake_by_irq <= 1'b0;
                        wake_by_rst <= 1'b0;
                        adc_start   <= adc_enabled && (sel_mode == `SMC_MODE_NOISE);
                    end
                end
                ST_SLEEP: begin
                    if (cnt_load) begin
                        state       <= ST_START;
                        wake_by_rst <= any_reset;
                    end
                end
                ST_START: begin
                    if (any_reset)
                        wake_by_rst <= 1'b1;
                    if (cnt_done) begin
                        // The interrupt is taken only if its cause is still present now.
                        if (wake_by_rst || any_reset) begin
                            state           <= ST_RUN;
                            reset_vector_go <= 1'b1;
                        end else if (wake_irq) begin
                            state       <= ST_HOLD;
                            wake_by_irq <= 1'b1;
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_HOLD: begin
                    if (cnt_done) begin
                        state    <= ST_RUN;
                        irq_take <= 1'b1;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Timed write of the detector disable bit
    // ****************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tseq                   <= `SMC_TSEQ_ZERO;
            brownout_sleep_disable <= 1'b0;
        end else begin
            if (brownout_sleep_disable_enable_wr)
                tseq <= `SMC_TSEQ_WIN;
            else if (tseq != `SMC_TSEQ_ZERO)
                tseq <= tseq - `SMC_TSEQ_ONE;
            if (brownout_sleep_disable_wr && !brownout_sleep_disable_enable_wr && tseq != `SMC_TSEQ_ZERO)
                brownout_sleep_disable <= brownout_sleep_disable_wdata;
        end
    end

    // ****************************************************************
    // Clock domain and oscillator gating
    // ****************************************************************
    // Gating only stops clocks; no storage is cleared, so memories keep state.
    // Clocks stay gated for the whole start-up state, so the core never sees a stray
    // clock edge between the end of the start-up count and the interrupt hold.
    wire sleeping = (state == ST_SLEEP) || (state == ST_START);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_clock_domain       <= 1'b1;
            program_store_clock     <= 1'b1;
            peripheral_clock_domain <= 1'b1;
            converter_clock_domain  <= 1'b1;
            async_timer_clock       <= 1'b1;
            main_osc_en             <= 1'b1;
            timer_osc_en            <= 1'b1;
            brownout_detector_en    <= 1'b1;
            asleep                  <= 1'b0;
        end else begin
            asleep                  <= sleeping || (state == ST_HOLD);
            core_clock_domain       <= !(sleeping || state == ST_HOLD);
            program_store_clock     <= !(sleeping || state == ST_HOLD);
            peripheral_clock_domain <= !sleeping || (mode == `SMC_MODE_IDLE);
            converter_clock_domain  <= !sleeping || (mode == `SMC_MODE_IDLE) ||
                                       (mode == `SMC_MODE_NOISE);
            async_timer_clock       <= !sleeping || (mode == `SMC_MODE_IDLE) ||
                                       (timer2_async && (mode == `SMC_MODE_NOISE || is_save(mode)));
            timer_osc_en            <= !sleeping || (timer2_async && !is_deep(mode)) ||
                                       (timer2_async && is_save(mode));
            main_osc_en             <= !sleeping || !is_deep(mode) ||
                                       mode == `SMC_MODE_STANDBY || mode == `SMC_MODE_XSTANDBY ||
                                       (mode == `SMC_MODE_PSAVE && timer2_enabled && !timer2_async);
            brownout_detector_en    <= !(state == ST_SLEEP && bod_was_off);
        end
    end
endmodule

// ---- smc_core_model.sv ----
// Behavioural core model that issues sleep instructions and a watchdog wake request.
`timescale 1ns/100ps
// ****************************************************************
// Core side
// ****************************************************************
module smc_core_model (
    input  wire clk,
    input  wire rstn,
    input  wire go_sleep,
    input  wire go_wake,
    input  wire irq_take,
    output reg  sleep_instr,
    output reg  wdt_irq
);
    // The request stays up until the handler runs, so a slow wake never loses it.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_instr <= 1'b0;
            wdt_irq     <= 1'b0;
        end else begin
            sleep_instr <= go_sleep;
            if (irq_take)
                wdt_irq <= 1'b0;
            else if (go_wake)
                wdt_irq <= 1'b1;
        end
    end
endmodule

// ---- smc_sleep_chk.sv ----
// Concurrent checks on the ports of the sleep mode controller.
`timescale 1ns/100ps
module smc_sleep_chk (
    input wire       clk,
    input wire       rstn,
    input wire       sleep_instr,
    input wire       sleep_arm,
    input wire [2:0] sleep_select,
    input wire       adc_enabled,
    input wire       brownout_sleep_disable_wr,
    input wire       core_clock_domain,
    input wire       program_store_clock,
    input wire       peripheral_clock_domain,
    input wire       converter_clock_domain,
    input wire       main_osc_en,
    input wire       brownout_detector_en,
    input wire       brownout_sleep_disable,
    input wire       adc_start,
    input wire       irq_take,
    input wire       reset_vector_go,
    input wire       asleep
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****************************************************************
    // Entry, gating and wake
    // ****************************************************************
    no_arm_a: assert property (
        core_clock_domain && !asleep && sleep_instr && !sleep_arm ##1 !sleep_instr |=> !asleep)
        else $error("sleep without arm");
    idle_gate_a: assert property (
        $rose(asleep) && sleep_select == 3'h0 |-> !core_clock_domain && !program_store_clock
        && peripheral_clock_domain && converter_clock_domain && main_osc_en) else $error("idle gating");
    noise_gate_a: assert property (
        $rose(asleep) && sleep_select == 3'h1 |-> !core_clock_domain
        && !peripheral_clock_domain && converter_clock_domain) else $error("noise gating");
    pdown_gate_a: assert property (
        $rose(asleep) && sleep_select == 3'h2 |-> !main_osc_en && !converter_clock_domain)
        else $error("power-down gating");
    adc_kick_a: assert property (
        core_clock_domain && !asleep && sleep_instr && sleep_arm && sleep_select == 3'h1
        && adc_enabled |-> ##[1:3] adc_start) else $error("no conversion start");
    bod_hold_a: assert property (
        !brownout_sleep_disable_wr && !$past(brownout_sleep_disable_wr) && !$past(brownout_sleep_disable_wr, 2) |-> $stable(brownout_sleep_disable))
        else $error("disable bit changed");
    bod_off_a: assert property (
        $rose(asleep) && brownout_sleep_disable && sleep_select[1] |-> ##[0:2] !brownout_detector_en)
        else $error("detector left on");
    irq_resume_a: assert property (
        irq_take |-> !core_clock_domain ##1 core_clock_domain)
        else $error("no resume after irq");
    reset_vec_a: assert property (reset_vector_go |-> !irq_take) else $error("irq with reset");
    cover property ($rose(asleep) && sleep_select == 3'h0);
    cover property (irq_take);
    cover property (reset_vector_go);
endmodule
bind smc_sleep_ctrl smc_sleep_chk smc_sleep_chk_i (.*);

// ---- tb_top.sv ----
// Self-checking bench for the sleep mode controller.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    reg        clk = 1'b0, rstn = 1'b0, go_sleep = 1'b0, go_wake = 1'b0, sleep_arm = 1'b1;
    reg  [2:0] sleep_select = 3'h0, ext_irq_level_mode = 3'h0;
    reg  [3:0] clock_select_fuse = 4'h0;
    reg        brownout_sleep_disable_enable_wr = 1'b0, brownout_sleep_disable_wr = 1'b0, brownout_sleep_disable_wdata = 1'b0, global_irq_en = 1'b1, adc_enabled = 1'b0;
    reg  [1:0] timer2_irq_mask = 2'h0;
    reg  [8:0] src = 9'h000;
    wire       sleep_instr, wdt_irq, core_clock_domain, program_store_clock, peripheral_clock_domain;
    wire       converter_clock_domain, async_timer_clock, main_osc_en, timer_osc_en, brownout_detector_en;
    wire       brownout_sleep_disable, adc_start, irq_take, reset_vector_go, asleep;
    wire [6:0] clkv = {core_clock_domain, program_store_clock, peripheral_clock_domain, converter_clock_domain,
                       async_timer_clock, main_osc_en, timer_osc_en};
    int        fail_count = 0, samples_checked = 0, cycles = 0, lat, lat0, adc_cnt = 0, adc0, n, i;
    reg  [6:0] snap;
    reg        sbod, rv;
    localparam [20:0] MD = {3'h7, 3'h6, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam [48:0] EV = {7'h07, 7'h02, 7'h1f, 7'h05, 7'h00, 7'h0f, 7'h1f};
    localparam [48:0] MK = {7'h7f, 7'h7f, 7'h7f, 7'h7d, 7'h7f, 7'h7f, 7'h7f};
    localparam [83:0] DL = {12'd5, 12'd5, 12'd0, 12'd271, 12'd15, 12'd0, 12'd0};
    smc_sleep_ctrl smc_sleep_ctrl_i (.*, .timer2_enabled(1'b1), .timer2_async(1'b1), .ext_reset_pin(1'b0),
        .wdt_reset(src[8]), .bod_reset(1'b0), .twi_match(src[1]), .timer_irq(src[2]), .timer2_event({1'b0, src[7]}),
        .store_ready_irq(src[3]), .adc_done_irq(src[0]), .ext_irq_pin({2'b00, src[6]}), .pin_change_irq(src[4]),
        .other_io_irq(src[5]));
    smc_core_model smc_core_model_i (.*);
    always #2.5 clk = ~clk;
    always @(negedge clk) if (adc_start === 1'b1) adc_cnt++;
    // ****************************************************************
    // Shared steps
    // ****************************************************************
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            `CHK("cycle limit", 0, 1)
            stop_test;
        end
    end
    // Enters mode m, offers wake cause s (zero: partner watchdog irq) and expects a wake or none within lim.
    task sw(input [2:0] m, input [8:0] s, input e, input int lim);
        begin
            @(negedge clk);
            sleep_select = m;
            clock_select_fuse = (m == 3'h3) ? 4'h1 : 4'h0;
            go_sleep = 1'b1;
            @(negedge clk);
            go_sleep = 1'b0;
            repeat (4) @(negedge clk);
            snap = clkv;
            sbod = brownout_detector_en;
            `CHK("asleep", 1'b1, asleep)
            if (s == 9'h000) go_wake = 1'b1; else src = s;
            lat = 0;
            rv = 1'b0;
            while (irq_take !== 1'b1 && rv !== 1'b1 && lat < lim) begin
                @(negedge clk);
                go_wake = 1'b0;
                rv = reset_vector_go;
                lat++;
            end
            `CHK("wake", e, lat < lim)
            src = 9'h000;
            n = 0;
            go_wake = !(lat < lim);
            while (go_wake && irq_take !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
            go_wake = 1'b0;
            repeat (4) @(negedge clk);
        end
    endtask
    task bw(input en, input d);
        begin
            @(negedge clk);
            brownout_sleep_disable_enable_wr = en;
            @(negedge clk);
            brownout_sleep_disable_enable_wr = 1'b0;
            brownout_sleep_disable_wdata = d;
            brownout_sleep_disable_wr = 1'b1;
            @(negedge clk);
            brownout_sleep_disable_wr = 1'b0;
            @(negedge clk);
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset_noarm;
        begin
            `CHK("clocks", 7'h7f, clkv)
            `CHK("disable bit", 1'b0, brownout_sleep_disable)
            sleep_arm = 1'b0;
            go_sleep = 1'b1;
            @(negedge clk);
            go_sleep = 1'b0;
            repeat (5) @(negedge clk);
            `CHK("no arm", 1'b0, asleep)
            sleep_arm = 1'b1;
        end
    endtask
    task t_modes;
        for (i = 0; i < 7; i++) begin
            sw(MD[i*3+:3], 9'h000, 1'b1, 2000);
            if (i == 0) lat0 = lat;
            `CHK("gating", EV[i*7+:7] & MK[i*7+:7], snap & MK[i*7+:7])
            `CHK("wake time", DL[i*12+:12], lat - lat0)
        end
    endtask
    task t_sources;
        begin
            adc_enabled = 1'b1;
            adc0 = adc_cnt;
            for (i = 0; i < 5; i++) sw(3'h1, 9'h001 << i, 1'b1, 400);
            sw(3'h1, 9'h020, 1'b0, 300);
            `CHK("conversions", 6, adc_cnt - adc0)
            adc_enabled = 1'b0;
            sw(3'h2, 9'h040, 1'b0, 300);
            sw(3'h0, 9'h040, 1'b1, 400);
            ext_irq_level_mode = 3'h1;
            sw(3'h2, 9'h040, 1'b1, 400);
            sw(3'h2, 9'h004, 1'b0, 300);
            sw(3'h3, 9'h080, 1'b0, 300);
            timer2_irq_mask = 2'h1;
            global_irq_en = 1'b0;
            sw(3'h3, 9'h080, 1'b0, 300);
            global_irq_en = 1'b1;
            sw(3'h3, 9'h080, 1'b1, 600);
            sw(3'h2, 9'h100, 1'b1, 400);
            `CHK("reset vector", 1'b1, rv)
        end
    endtask
    // A wake cause that drops before start-up ends still wakes the core but takes no interrupt.
    task t_vanish;
        begin
            @(negedge clk);
            sleep_select = 3'h2;
            clock_select_fuse = 4'h0;
            go_sleep = 1'b1;
            @(negedge clk);
            go_sleep = 1'b0;
            repeat (4) @(negedge clk);
            src = 9'h002;
            @(negedge clk);
            src = 9'h000;
            rv = 1'b0;
            repeat (40) begin
                @(negedge clk);
                if (irq_take === 1'b1) rv = 1'b1;
            end
            `CHK("vanished wake", 1'b0, asleep)
            `CHK("vanished irq", 1'b0, rv)
        end
    endtask
    task t_brownout_sleep_disable;
        begin
            bw(1'b0, 1'b1);
            `CHK("unlocked write", 1'b0, brownout_sleep_disable)
            bw(1'b1, 1'b1);
            `CHK("timed write", 1'b1, brownout_sleep_disable)
            sw(3'h2, 9'h000, 1'b1, 13000);
            `CHK("detector asleep", 1'b0, sbod)
            `CHK("long wake", 11999, lat - lat0)
            `CHK("detector awake", 1'b1, brownout_detector_en)
            bw(1'b1, 1'b0);
            `CHK("cleared", 1'b0, brownout_sleep_disable)
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_reset_noarm;
        t_modes;
        t_sources;
        t_vanish;
        t_brownout_sleep_disable;
        stop_test;
    end
endmodule
